// file: hw/gpib_serial_poll_responder.sv
`timescale 1ns/1ps
`include "gpib_serial_poll_responder_cfg.svh"

module gpib_serial_poll_responder (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_irq,
  input  wire logic       i_atn,
  input  wire logic       i_spe,
  input  wire logic       i_spd,
  input  wire logic       i_my_ta,
  input  wire logic       i_my_la,
  input  wire logic       i_my_sa,
  input  wire logic       i_other_pa,
  input  wire logic       i_unt,
  input  wire logic       i_unl,
  input  wire logic       i_rem,
  input  wire logic       i_rfd_pin,
  input  wire logic       i_dac_pin,
  output logic      [7:0] o_dio,
  output logic            o_dio_oe,
  output logic            o_dav_out,
  output logic            o_dav_oe,
  output logic            o_srq_out,
  output logic            o_srq_oe
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  gpib_serial_poll_responder_pkg::talker_state_type   talker;
  gpib_serial_poll_responder_pkg::listener_state_type listener;
  gpib_serial_poll_responder_pkg::source_state_type   source;

  logic [7:0] serial_poll;
  logic [7:0] data_out;
  logic       srq_pending;
  logic       srq_armed;
  logic       spas;
  logic       accepted;
  logic       nba;
  logic       ext_addr;
  logic       mask_cmd;
  logic       mask_master;
  logic       remote_local_change_flag;
  logic       rem_prev;
  logic [2:0] rfd_sync;
  logic [2:0] dac_sync;
  logic       rfd;
  logic       dac;

  logic       wr_spr;
  logic       wr_imr;
  logic       wr_ext;
  logic       wr_dout;
  logic       rd_isr;
  logic       rd_csr;
  logic       spas_entry;
  logic       tacs;
  logic       hold_rsv;
  logic       irq_cond;
  logic       rem_change;
  logic       send_active;

  function automatic logic hit(input logic strobe, input logic [2:0] addr, input logic [2:0] target);
    hit = strobe && (addr == target);
  endfunction

  assign wr_spr      = hit(i_wr, i_addr, `ADDR_SERIAL_POLL);
  assign wr_imr      = hit(i_wr, i_addr, `ADDR_INT_STATUS);
  assign wr_ext      = hit(i_wr, i_addr, `ADDR_ADDR_STATUS);
  assign wr_dout     = hit(i_wr, i_addr, `ADDR_DATA_OUT);
  assign rd_isr      = hit(i_rd, i_addr, `ADDR_INT_STATUS);
  assign rd_csr      = hit(i_rd, i_addr, `ADDR_CMD_STATUS);

  assign spas_entry  = i_spe && !spas && (talker == gpib_serial_poll_responder_pkg::T_ADDRESSED);
  assign tacs        = (talker == gpib_serial_poll_responder_pkg::T_ADDRESSED) && !i_atn && !spas;
  assign hold_rsv    = spas && !accepted;
  assign irq_cond    = spas && mask_cmd && mask_master;
  assign rem_change  = i_rem != rem_prev;
  assign send_active = spas || (tacs && nba);

  // ----------------------------------------
  // Handshake pin synchronisers
  // ----------------------------------------
  // A level is taken only once stages two and three agree
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rfd_sync <= 3'h0;
      dac_sync <= 3'h0;
      rfd      <= 1'b0;
      dac      <= 1'b0;
    end else begin
      rfd_sync <= {rfd_sync[1:0], i_rfd_pin};
      dac_sync <= {dac_sync[1:0], i_dac_pin};
      if (rfd_sync[1] == rfd_sync[2]) begin
        rfd <= rfd_sync[2];
      end
      if (dac_sync[1] == dac_sync[2]) begin
        dac <= dac_sync[2];
      end
    end
  end

  // ----------------------------------------
  // Addressing
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      talker <= gpib_serial_poll_responder_pkg::T_IDLE;
    end else if (i_unt) begin
      talker <= gpib_serial_poll_responder_pkg::T_IDLE;
    end else if (!ext_addr) begin
      if (i_my_ta) begin
        talker <= gpib_serial_poll_responder_pkg::T_ADDRESSED;
      end
    end else if (i_my_ta) begin
      talker <= gpib_serial_poll_responder_pkg::T_PRIMARY;
    end else if (talker == gpib_serial_poll_responder_pkg::T_PRIMARY) begin
      if (i_other_pa) begin
        talker <= gpib_serial_poll_responder_pkg::T_IDLE;
      end else if (i_my_sa) begin
        talker <= gpib_serial_poll_responder_pkg::T_ADDRESSED;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      listener <= gpib_serial_poll_responder_pkg::L_IDLE;
    end else if (i_unl) begin
      listener <= gpib_serial_poll_responder_pkg::L_IDLE;
    end else if (!ext_addr) begin
      if (i_my_la) begin
        listener <= gpib_serial_poll_responder_pkg::L_ADDRESSED;
      end
    end else if (i_my_la) begin
      listener <= gpib_serial_poll_responder_pkg::L_PRIMARY;
    end else if (listener == gpib_serial_poll_responder_pkg::L_PRIMARY) begin
      if (i_other_pa) begin
        listener <= gpib_serial_poll_responder_pkg::L_IDLE;
      end else if (i_my_sa) begin
        listener <= gpib_serial_poll_responder_pkg::L_ADDRESSED;
      end
    end
  end

  // ----------------------------------------
  // Serial poll state
  // ----------------------------------------
  // Flag is the state itself, never a latched copy
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      spas <= 1'b0;
    end else if (spas_entry) begin
      spas <= 1'b1;
    end else if (i_spd) begin
      spas <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      accepted <= 1'b0;
    end else if (spas_entry) begin
      accepted <= 1'b0;
    end else if (spas && source == gpib_serial_poll_responder_pkg::SH_DAV_LOW && dac) begin
      accepted <= 1'b1;
    end
  end

  // ----------------------------------------
  // Service request
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      serial_poll <= `BYTE_ZERO;
    end else if (wr_spr) begin
      serial_poll <= i_wdata;
      if (hold_rsv && !i_wdata[`RSV_BIT]) begin
        serial_poll[`RSV_BIT] <= serial_poll[`RSV_BIT];
      end
    end
  end

  // Set by a fresh rsv write wins over the poll-entry clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      srq_pending <= 1'b0;
    end else if (wr_spr && i_wdata[`RSV_BIT] && srq_armed) begin
      srq_pending <= 1'b1;
    end else if (spas_entry || (wr_spr && !i_wdata[`RSV_BIT] && !hold_rsv)) begin
      srq_pending <= 1'b0;
    end
  end

  // Poll consumes the request; only a low write re-arms it
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      srq_armed <= 1'b1;
    end else if (wr_spr && !i_wdata[`RSV_BIT] && !hold_rsv) begin
      srq_armed <= 1'b1;
    end else if (spas_entry) begin
      srq_armed <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_srq_out <= 1'b0;
      o_srq_oe  <= 1'b0;
    end else begin
      o_srq_out <= 1'b0;
      o_srq_oe  <= srq_pending && !spas && !spas_entry;
    end
  end

  // ----------------------------------------
  // Talker data byte
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      data_out <= `BYTE_ZERO;
    end else if (wr_dout) begin
      data_out <= i_wdata;
    end
  end

  // Survives an ATN takeover, so the byte is not lost in a poll
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      nba <= 1'b0;
    end else if (wr_dout) begin
      nba <= 1'b1;
    end else if (tacs && source == gpib_serial_poll_responder_pkg::SH_DAV_LOW && dac) begin
      nba <= 1'b0;
    end
  end

  // ----------------------------------------
  // Source handshake
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      source    <= gpib_serial_poll_responder_pkg::SH_IDLE;
      o_dio     <= `BYTE_ZERO;
      o_dio_oe  <= 1'b0;
      o_dav_out <= 1'b0;
      o_dav_oe  <= 1'b0;
    end else if (!send_active) begin
      source   <= gpib_serial_poll_responder_pkg::SH_IDLE;
      o_dio_oe <= 1'b0;
      o_dav_oe <= 1'b0;
    end else begin
      o_dav_out <= 1'b0;
      unique case (source)
        gpib_serial_poll_responder_pkg::SH_IDLE: begin
          o_dio    <= spas ? serial_poll : data_out;
          o_dio[`RSV_BIT] <= spas ? srq_pending : data_out[`RSV_BIT];
          o_dio_oe <= 1'b1;
          source   <= gpib_serial_poll_responder_pkg::SH_WAIT_RFD;
        end
        gpib_serial_poll_responder_pkg::SH_WAIT_RFD: begin
          if (rfd && !dac) begin
            o_dav_oe <= 1'b1;
            source   <= gpib_serial_poll_responder_pkg::SH_DAV_LOW;
          end
        end
        gpib_serial_poll_responder_pkg::SH_DAV_LOW: begin
          if (dac) begin
            o_dav_oe <= 1'b0;
            if (spas && nba) begin
              source <= gpib_serial_poll_responder_pkg::SH_WAIT_RFD;
            end else if (spas) begin
              source <= gpib_serial_poll_responder_pkg::SH_DONE;
            end else begin
              source <= gpib_serial_poll_responder_pkg::SH_IDLE;
            end
          end
        end
        gpib_serial_poll_responder_pkg::SH_DONE: begin
          source <= gpib_serial_poll_responder_pkg::SH_DONE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mask_cmd    <= 1'b0;
      mask_master <= 1'b0;
    end else if (wr_imr) begin
      mask_cmd    <= i_wdata[`CMD_BIT];
      mask_master <= i_wdata[`MASTER_MASK_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_addr <= 1'b0;
    end else if (wr_ext) begin
      ext_addr <= i_wdata[`EXT_ADDR_BIT];
    end
  end

  // ----------------------------------------
  // Remote/local change
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rem_prev <= 1'b0;
    end else begin
      rem_prev <= i_rem;
    end
  end

  // Change in the read cycle is kept, not cleared
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      remote_local_change_flag <= 1'b0;
    end else if (rem_change) begin
      remote_local_change_flag <= 1'b1;
    end else if (rd_csr) begin
      remote_local_change_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupt request
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq <= 1'b0;
    end else if (irq_cond) begin
      o_irq <= 1'b1;
    end else if (rd_isr) begin
      o_irq <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= `BYTE_ZERO;
    end else begin
      o_rdata <= `BYTE_ZERO;
      if (i_rd) begin
        unique case (i_addr)
          `ADDR_INT_STATUS: begin
            o_rdata[`CMD_BIT]    <= spas;
            o_rdata[`ORPHAN_BIT] <= o_irq && !spas;
          end
          `ADDR_CMD_STATUS: begin
            o_rdata[`SPAS_BIT] <= spas;
            o_rdata[`RLC_BIT]  <= remote_local_change_flag;
            o_rdata[`REM_BIT]  <= i_rem;
          end
          `ADDR_ADDR_STATUS: begin
            o_rdata[`TPAS_BIT]     <= talker == gpib_serial_poll_responder_pkg::T_PRIMARY;
            o_rdata[`LPAS_BIT]     <= listener == gpib_serial_poll_responder_pkg::L_PRIMARY;
            o_rdata[`EXT_READ_BIT] <= ext_addr;
          end
          `ADDR_SERIAL_POLL: begin
            o_rdata              <= serial_poll;
            o_rdata[`RSV_BIT]    <= srq_pending;
          end
          default: begin
            o_rdata <= `BYTE_ZERO;
          end
        endcase
      end
    end
  end

endmodule

// file: hw/gpib_serial_poll_responder_cfg.svh
`ifndef GPIB_SERIAL_POLL_RESPONDER_CFG_SVH
`define GPIB_SERIAL_POLL_RESPONDER_CFG_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_INT_STATUS   3'h0
`define ADDR_CMD_STATUS   3'h1
`define ADDR_ADDR_STATUS  3'h2
`define ADDR_SERIAL_POLL  3'h5
`define ADDR_DATA_OUT     3'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSV_BIT           6
`define CMD_BIT           2
`define SPAS_BIT          2
`define RLC_BIT           1
`define REM_BIT           0
`define ORPHAN_BIT        4
`define MASTER_MASK_BIT   7
`define EXT_ADDR_BIT      0
`define TPAS_BIT          1
`define LPAS_BIT          0
`define EXT_READ_BIT      2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BYTE_ZERO         8'h00

`endif

// file: hw/gpib_serial_poll_responder_pkg.sv
package gpib_serial_poll_responder_pkg;

  typedef enum logic [1:0] {
    T_IDLE,
    T_PRIMARY,
    T_ADDRESSED
  } talker_state_type;

  typedef enum logic [1:0] {
    L_IDLE,
    L_PRIMARY,
    L_ADDRESSED
  } listener_state_type;

  typedef enum logic [1:0] {
    SH_IDLE,
    SH_WAIT_RFD,
    SH_DAV_LOW,
    SH_DONE
  } source_state_type;

endpackage

// file: sim/gpib_serial_poll_responder_sva.sv
`timescale 1ns/1ps
module gpib_serial_poll_responder_sva (
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  input wire logic [2:0] i_addr,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic       i_atn,
  input wire logic       i_spe,
  input wire logic       i_spd,
  input wire logic       i_rfd_pin,
  input wire logic       i_dac_pin,
  input wire logic [7:0] o_rdata,
  input wire logic       o_irq,
  input wire logic [7:0] o_dio,
  input wire logic       o_dio_oe,
  input wire logic       o_dav_out,
  input wire logic       o_dav_oe,
  input wire logic       o_srq_out,
  input wire logic       o_srq_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  rd_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  open_drain_a: assert property (o_dav_out == 1'b0 && o_srq_out == 1'b0)
    else $error("open drain data level not low");
  // Four flops of pin sync (three stages plus the agreed level) sit in front of the source handshake
  dav_after_rfd_a: assert property ($rose(o_dav_oe) |-> $past(i_rfd_pin, 3) && !$past(i_dac_pin, 3))
    else $error("data valid without ready for data");
  dav_release_a: assert property ($fell(o_dav_oe) |-> $past(i_dac_pin, 3))
    else $error("data valid dropped before accept");
  dav_data_a: assert property (o_dav_oe |-> o_dio_oe && $stable(o_dio))
    else $error("status byte not held under data valid");
  spd_leave_a: assert property (i_spd ##1 i_atn [*2] |=> !o_dio_oe)
    else $error("data lines still driven after poll disable");
  irq_fall_a: assert property ($fell(o_irq) |-> $past(i_rd) && $past(i_addr) == 3'h0)
    else $error("interrupt dropped without status read");
  // Poll entry drops the pin one edge after SPE; a low rsv write takes two
  srq_drop_a: assert property ($fell(o_srq_oe) |-> $past(i_spe) || $past(i_wr, 2))
    else $error("service request dropped without cause");
endmodule

bind gpib_serial_poll_responder gpib_serial_poll_responder_sva chk (
  .i_clk, .i_arst_n, .i_addr, .i_wr, .i_rd, .i_atn, .i_spe, .i_spd, .i_rfd_pin, .i_dac_pin,
  .o_rdata, .o_irq, .o_dio, .o_dio_oe, .o_dav_out, .o_dav_oe, .o_srq_out, .o_srq_oe);

// file: sim/gpib_controller_model.sv
`timescale 1ns/1ps
module gpib_controller_model (
  input  wire logic       i_clk,
  input  wire logic       i_dav_oe,
  input  wire logic [7:0] i_dio,
  output logic            o_rfd,
  output logic            o_dac
);
  initial begin
    o_rfd = 1'b0;
    o_dac = 1'b0;
  end

  // One acceptor cycle; the caller never ends a poll mid-handshake
  task automatic accept(input int dly, output bit got, output logic [7:0] b);
    int n;
    got = 1'b0;
    b = 8'h00;
    repeat (dly) @(posedge i_clk);
    o_rfd <= 1'b1;
    for (n = 0; n < 20 && !got; n++) begin
      @(posedge i_clk);
      if (i_dav_oe === 1'b1) begin
        got = 1'b1;
        b = i_dio;
      end
    end
    o_rfd <= 1'b0;
    if (got) begin
      o_dac <= 1'b1;
      for (n = 0; n < 20 && i_dav_oe !== 1'b0; n++) @(posedge i_clk);
      o_dac <= 1'b0;
    end
  endtask
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; $display("wrong value at %0t: %h %h", $time, a, e); end end
module tb_top;
  logic       clk, arst_n, wr, rd, atn, remote_state_bit;
  logic [2:0] addr;
  logic [7:0] wdata, cmd, rdata, dio, code, b;
  logic       irq, dio_oe, dav_out, dav_oe, srq_out, srq_oe, rfd, dac;
  int         seed, bad_count, num_checks, davs;
  bit         got, pd;

  gpib_serial_poll_responder dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_irq(irq), .i_atn(atn), .i_spe(cmd[0]), .i_spd(cmd[1]),
    .i_my_ta(cmd[2]), .i_my_la(cmd[3]), .i_my_sa(cmd[4]), .i_other_pa(cmd[5]),
    .i_unt(cmd[6]), .i_unl(cmd[7]), .i_rem(remote_state_bit), .i_rfd_pin(rfd), .i_dac_pin(dac),
    .o_dio(dio), .o_dio_oe(dio_oe), .o_dav_out(dav_out), .o_dav_oe(dav_oe),
    .o_srq_out(srq_out), .o_srq_oe(srq_oe));

  gpib_controller_model ctl (.i_clk(clk), .i_dav_oe(dav_oe), .i_dio(dio), .o_rfd(rfd), .o_dac(dac));

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    if (dav_oe === 1'b1 && !pd) davs++;
    pd = (dav_oe === 1'b1);
  end

  // ----
  // Bus and command tasks
  // ----
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  // Commands arrive as one-cycle decoded pulses
  task automatic cmdp(input int n);
    @(posedge clk);
    cmd <= 8'h01 << n;
    @(posedge clk);
    cmd <= 8'h00;
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end

  // ----
  // Main sequence
  // ----
  initial begin
    {clk, wr, rd, atn, remote_state_bit, addr, wdata, cmd} = '0;
    arst_n = 1'b0;
    seed = 60;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    wr_reg(3'h0, 8'h84);
    code = (8'($random(seed)) & 8'hbf) | 8'h40;
    wr_reg(3'h5, code);
    repeat (3) @(posedge clk);
    `CHK(srq_oe, 1'b1)
    rd_reg(3'h5, code);
    rd_reg(3'h3, 8'h00);
    cmdp(0);
    repeat (3) @(posedge clk);
    `CHK(srq_oe, 1'b1)
    rd_reg(3'h1, 8'h00);
    note("request");
    @(posedge clk) atn <= 1'b1;
    cmdp(2);
    cmdp(0);
    repeat (3) @(posedge clk);
    `CHK(srq_oe, 1'b0)
    `CHK({dio_oe, dio & 8'hbf}, {1'b1, code & 8'hbf})
    `CHK(irq, 1'b1)
    rd_reg(3'h1, 8'h04);
    rd_reg(3'h5, code & 8'hbf);
    wr_reg(3'h5, 8'h00);
    @(posedge clk) atn <= 1'b0;
    davs = 0;
    ctl.accept(($random(seed) & 7) + 1, got, b);
    `CHK({got, b & 8'hbf}, {1'b1, code & 8'hbf})
    ctl.accept(1, got, b);
    `CHK({got, davs[3:0]}, {1'b0, 4'h1})
    @(posedge clk) atn <= 1'b1;
    cmdp(1);
    repeat (3) @(posedge clk);
    rd_reg(3'h1, 8'h00);
    rd_reg(3'h0, 8'h10);
    `CHK(irq, 1'b0)
    wr_reg(3'h5, code);
    repeat (3) @(posedge clk);
    `CHK(srq_oe, 1'b0)
    wr_reg(3'h5, 8'h00);
    wr_reg(3'h5, code);
    repeat (3) @(posedge clk);
    `CHK(srq_oe, 1'b1)
    note("poll");
    @(posedge clk) remote_state_bit <= 1'b1;
    rd_reg(3'h1, 8'h03);
    rd_reg(3'h1, 8'h01);
    @(posedge clk) remote_state_bit <= 1'b0;
    rd_reg(3'h1, 8'h02);
    note("remote");
    // Bus taken back in the very cycle the byte is loaded
    @(posedge clk) atn <= 1'b0;
    repeat (3) @(posedge clk);
    atn <= 1'b1;
    addr <= 3'h7;
    wdata <= ~code;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    cmdp(0);
    @(posedge clk) atn <= 1'b0;
    davs = 0;
    ctl.accept(2, got, b);
    ctl.accept(1, got, b);
    `CHK({got, davs[3:0]}, {1'b1, 4'h2})
    @(posedge clk) atn <= 1'b1;
    cmdp(1);
    note("pending");
    cmdp(6);
    cmdp(7);
    wr_reg(3'h2, 8'h01);
    rd_reg(3'h2, 8'h04);
    cmdp(3);
    rd_reg(3'h2, 8'h05);
    cmdp(5);
    rd_reg(3'h2, 8'h04);
    cmdp(2);
    rd_reg(3'h2, 8'h06);
    cmdp(4);
    rd_reg(3'h2, 8'h04);
    note("extended");
    results();
  end
endmodule
